/* File: pkg/i2c_status_map.vh */
// Register map, field positions and reset values of the I2C slave status block
`ifndef I2C_STATUS_MAP_VH
`define I2C_STATUS_MAP_VH

// ============================================================
// Register byte addresses
`define ADDR_STATUS0 32'hFFFF_082C
`define ADDR_STATUS1 32'hFFFF_092C
`define ADDR_CONTROL0 32'hFFFF_0830
`define ADDR_CONTROL1 32'hFFFF_0930

// ============================================================
// Register select codes (one-hot)
`define SEL_NONE 4'h0
`define SEL_STATUS0 4'h1
`define SEL_STATUS1 4'h2
`define SEL_CONTROL0 4'h4
`define SEL_CONTROL1 4'h8

// ============================================================
// Reset values
`define STATUS_RESET 16'h0000
`define CONTROL_RESET 16'h0000
`define RDATA_RESET 32'h0000_0000
`define IRQ_RESET 2'h0
`define UPPER_ZERO 16'h0000

// ============================================================
// Status field positions
`define ST_RESERVED 15
`define ST_START 14
`define ST_REPS 13
`define ST_IDX_HI 12
`define ST_IDX_LO 11
`define ST_SS 10
`define ST_GCT_HI 9
`define ST_GCT_LO 8
`define ST_LOW_HI 7

// ============================================================
// Control field positions
`define CTL_GC_EN 2
`define CTL_STOP_IE 8
`define CTL_GC_CLR 9
`define CTL_WRITE_MASK 16'h0104

// ============================================================
// General call type codes
`define GCT_NONE 2'h0
`define GCT_RESET_PROG 2'h1
`define GCT_PROG 2'h2
`define GCT_ALT 2'h3
`define INDEX_ZERO 2'h0

// ============================================================
// AHB-Lite codes
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`define HRESP_OKAY 1'b0

`endif

/* File: rtl/i2c_status_channel.v */
// Status flags of one I2C slave channel
`timescale 1ns/100ps
`default_nettype none
`include "i2c_status_map.vh"

module i2c_status_channel (
    input wire clock,
    input wire rst_n,
    input wire addr_match,
    input wire [1:0] addr_index,
    input wire start_byte,
    input wire gc_addr,
    input wire rep_start,
    input wire stop_cond,
    input wire gc_reset_cmd,
    input wire gc_prog_cmd,
    input wire gc_alt_match,
    input wire gc_enable,
    input wire gc_clear,
    input wire status_read,
    output wire [15:0] status
);

    // ============================================================
    // Flag state
    reg start_detected_flag_ff;
    reg repeated_start_flag_ff;
    reg [1:0] matched_address_index_ff;
    reg stop_after_start_flag_ff;
    reg [1:0] general_call_type_ff;
    reg matched_ff;
    reg nxt_start_detected_flag;
    reg nxt_repeated_start_flag;
    reg [1:0] nxt_matched_address_index;
    reg nxt_stop_after_start_flag;
    reg [1:0] nxt_general_call_type;
    reg nxt_matched;
    wire start_set;
    wire ss_set;

    assign start_set = addr_match | start_byte | (gc_addr & gc_enable);
    assign ss_set = stop_cond & matched_ff;

    // ============================================================
    // Next-state logic; every set wins over a clear in the same cycle
    always @* begin
        nxt_start_detected_flag = start_detected_flag_ff;
        nxt_repeated_start_flag = repeated_start_flag_ff;
        nxt_matched_address_index = matched_address_index_ff;
        nxt_stop_after_start_flag = stop_after_start_flag_ff;
        nxt_general_call_type = general_call_type_ff;
        nxt_matched = matched_ff;
        // General call reset returns the flags to default
        if (gc_reset_cmd) begin
            nxt_start_detected_flag = 1'b0;
            nxt_repeated_start_flag = 1'b0;
            nxt_matched_address_index = `INDEX_ZERO;
            nxt_stop_after_start_flag = 1'b0;
            nxt_matched = 1'b0;
        end
        if (stop_cond) begin
            nxt_start_detected_flag = 1'b0;
            nxt_repeated_start_flag = 1'b0;
            nxt_matched = 1'b0;
        end
        if (status_read) begin
            nxt_repeated_start_flag = 1'b0;
            nxt_stop_after_start_flag = 1'b0;
        end
        if (start_set) begin
            nxt_start_detected_flag = 1'b1;
            nxt_matched = 1'b1;
        end
        if (addr_match) begin
            nxt_matched_address_index = addr_index;
        end
        if (rep_start) begin
            nxt_repeated_start_flag = 1'b1;
        end
        if (ss_set) begin
            nxt_stop_after_start_flag = 1'b1;
        end
        // General call reset sets the type to reset-and-program unless an alternative match in the same cycle wins; only the clear bit clears it
        if (gc_clear) begin
            nxt_general_call_type = `GCT_NONE;
        end
        if (gc_alt_match) begin
            nxt_general_call_type = `GCT_ALT;
        end else if (gc_reset_cmd) begin
            nxt_general_call_type = `GCT_RESET_PROG;
        end else if (gc_prog_cmd) begin
            nxt_general_call_type = `GCT_PROG;
        end
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            start_detected_flag_ff <= 1'b0;
            repeated_start_flag_ff <= 1'b0;
            matched_address_index_ff <= `INDEX_ZERO;
            stop_after_start_flag_ff <= 1'b0;
            general_call_type_ff <= `GCT_NONE;
            matched_ff <= 1'b0;
        end else begin
            start_detected_flag_ff <= nxt_start_detected_flag;
            repeated_start_flag_ff <= nxt_repeated_start_flag;
            matched_address_index_ff <= nxt_matched_address_index;
            stop_after_start_flag_ff <= nxt_stop_after_start_flag;
            general_call_type_ff <= nxt_general_call_type;
            matched_ff <= nxt_matched;
        end
    end

    // ============================================================
    // Status word; reserved and low bits read zero
    assign status[`ST_RESERVED] = 1'b0;
    assign status[`ST_START] = start_detected_flag_ff;
    assign status[`ST_REPS] = repeated_start_flag_ff;
    assign status[`ST_IDX_HI:`ST_IDX_LO] = matched_address_index_ff;
    assign status[`ST_SS] = stop_after_start_flag_ff;
    assign status[`ST_GCT_HI:`ST_GCT_LO] = general_call_type_ff;
    assign status[`ST_LOW_HI:0] = 8'h00;

endmodule // i2c_status_channel

`default_nettype wire

/* File: rtl/i2c_slave_status_flags.v */
// Two-channel I2C slave status flags with AHB-Lite register access
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_status_map.vh"

module i2c_slave_status_flags (
    input wire clock,
    input wire rst_n,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    // Bus events from the slave engines, one bit per channel; addr_index0/addr_index1 carry two index bits per channel
    input wire [1:0] addr_match,
    input wire [1:0] addr_index0,
    input wire [1:0] addr_index1,
    input wire [1:0] start_byte,
    input wire [1:0] gc_addr,
    input wire [1:0] rep_start,
    input wire [1:0] stop_cond,
    input wire [1:0] gc_reset_cmd,
    input wire [1:0] gc_prog_cmd,
    input wire [1:0] gc_alt_match,
    // To the slave engines and the interrupt controller
    output wire [1:0] general_call_enable,
    output wire [1:0] stop_irq
);

    // ============================================================
    // Address decode
    function [3:0] reg_select;
        input [31:0] addr;
        begin
            case (addr)
                `ADDR_STATUS0: reg_select = `SEL_STATUS0;
                `ADDR_STATUS1: reg_select = `SEL_STATUS1;
                `ADDR_CONTROL0: reg_select = `SEL_CONTROL0;
                `ADDR_CONTROL1: reg_select = `SEL_CONTROL1;
                default: reg_select = `SEL_NONE;
            endcase
        end
    endfunction

    // ============================================================
    // Address phase
    wire trans_valid;
    wire accept;
    wire [3:0] addr_sel;
    wire rd_accept;
    wire wr_accept;

    assign trans_valid = (htrans == `HTRANS_NONSEQ) | (htrans == `HTRANS_SEQ);
    assign accept = hsel & hready & trans_valid;
    assign addr_sel = reg_select(haddr);
    assign rd_accept = accept & ~hwrite;
    assign wr_accept = accept & hwrite;

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = `HRESP_OKAY;

    // ============================================================
    // Write data phase
    reg [3:0] wr_sel_ff;
    reg [3:0] nxt_wr_sel;

    always @* begin
        nxt_wr_sel = `SEL_NONE;
        if (wr_accept) begin
            nxt_wr_sel = addr_sel;
        end
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            wr_sel_ff <= `SEL_NONE;
        end else begin
            wr_sel_ff <= nxt_wr_sel;
        end
    end

    // ============================================================
    // Per-channel control registers and status flags
    wire [15:0] status_word [0:1];
    wire [15:0] nxt_ctl_word [0:1];
    wire [1:0] status_read;
    wire [1:0] ctl_write;
    wire [1:0] gc_clear;
    wire [1:0] ss_flag;
    wire [1:0] stop_ie;
    wire [3:0] status_sel [0:1];
    wire [3:0] control_sel [0:1];
    wire [1:0] addr_index [0:1];

    assign status_sel[0] = `SEL_STATUS0;
    assign status_sel[1] = `SEL_STATUS1;
    assign control_sel[0] = `SEL_CONTROL0;
    assign control_sel[1] = `SEL_CONTROL1;
    assign addr_index[0] = addr_index0;
    assign addr_index[1] = addr_index1;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : chan
            reg [15:0] ctl_ff;
            reg [15:0] nxt_ctl;

            // Read clear takes effect at the address-phase edge
            assign status_read[ch] = rd_accept &
                (addr_sel == status_sel[ch]);
            assign ctl_write[ch] = (wr_sel_ff == control_sel[ch]);

            // Clear bit is a one-cycle strobe, never stored
            assign gc_clear[ch] = ctl_write[ch] &
                hwdata[`CTL_GC_CLR];

            always @* begin
                nxt_ctl = ctl_ff;
                if (ctl_write[ch]) begin
                    nxt_ctl = hwdata[15:0] & `CTL_WRITE_MASK;
                end
            end

            always @(posedge clock) begin
                if (!rst_n) begin
                    ctl_ff <= `CONTROL_RESET;
                end else begin
                    ctl_ff <= nxt_ctl;
                end
            end

            assign nxt_ctl_word[ch] = nxt_ctl;
            assign stop_ie[ch] = ctl_ff[`CTL_STOP_IE];
            assign general_call_enable[ch] = ctl_ff[`CTL_GC_EN];

            i2c_status_channel flags (
                .clock(clock),
                .rst_n(rst_n),
                .addr_match(addr_match[ch]),
                .addr_index(addr_index[ch]),
                .start_byte(start_byte[ch]),
                .gc_addr(gc_addr[ch]),
                .rep_start(rep_start[ch]),
                .stop_cond(stop_cond[ch]),
                .gc_reset_cmd(gc_reset_cmd[ch]),
                .gc_prog_cmd(gc_prog_cmd[ch]),
                .gc_alt_match(gc_alt_match[ch]),
                .gc_enable(ctl_ff[`CTL_GC_EN]),
                .gc_clear(gc_clear[ch]),
                .status_read(status_read[ch]),
                .status(status_word[ch])
            );

            assign ss_flag[ch] = status_word[ch][`ST_SS];
        end
    endgenerate

    // ============================================================
    // Interrupt requests, registered level
    reg [1:0] stop_irq_ff;
    wire [1:0] nxt_stop_irq;

    assign nxt_stop_irq = ss_flag & stop_ie;

    always @(posedge clock) begin
        if (!rst_n) begin
            stop_irq_ff <= `IRQ_RESET;
        end else begin
            stop_irq_ff <= nxt_stop_irq;
        end
    end

    assign stop_irq = stop_irq_ff;

    // ============================================================
    // Read data, captured at the address-phase edge
    reg [31:0] hrdata_ff;
    reg [31:0] nxt_hrdata;

    // Control readback forwards a write still in its data phase
    always @* begin
        nxt_hrdata = hrdata_ff;
        if (rd_accept) begin
            case (addr_sel)
                `SEL_STATUS0: nxt_hrdata = {`UPPER_ZERO, status_word[0]};
                `SEL_STATUS1: nxt_hrdata = {`UPPER_ZERO, status_word[1]};
                `SEL_CONTROL0: nxt_hrdata = {`UPPER_ZERO, nxt_ctl_word[0]};
                `SEL_CONTROL1: nxt_hrdata = {`UPPER_ZERO, nxt_ctl_word[1]};
                default: nxt_hrdata = `RDATA_RESET;
            endcase
        end
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            hrdata_ff <= `RDATA_RESET;
        end else begin
            hrdata_ff <= nxt_hrdata;
        end
    end

    assign hrdata = hrdata_ff;

endmodule // i2c_slave_status_flags

`default_nettype wire

/* File: verification/status_checker_properties.sv */
// Checker of the status block's bus and event outputs
`timescale 1ns/100ps
`default_nettype none
`include "i2c_status_map.vh"
module status_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [1:0] stop_cond,
    input wire logic [1:0] gc_reset_cmd,
    input wire logic [1:0] general_call_enable,
    input wire logic [1:0] stop_irq
);
    wire logic tk = hsel && hready && htrans[1];
    wire logic rd_tk = tk && !hwrite;
    wire logic wr_tk = tk && hwrite;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ============================================================
    // Properties
    sequence ctl0_write;
        wr_tk && haddr == `ADDR_CONTROL0 ##1 1'b1;
    endsequence
    ready_okay_a: assert property (hreadyout && !hresp)
        else $error("wait state or error response");
    reset_clear_a: assert property ($rose(rst_n) |->
        hrdata == 32'h0000_0000 && stop_irq == 2'b00)
        else $error("outputs not cleared by reset");
    rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_tk))
        else $error("read data moved without a read");
    status_fmt_a: assert property (
        rd_tk && haddr == `ADDR_STATUS0 |=>
        hrdata[31:15] == 17'h0 && hrdata[7:0] == 8'h00)
        else $error("reserved status bits not zero");
    gce_write_a: assert property (ctl0_write |=>
        general_call_enable[0] == $past(hwdata[`CTL_GC_EN]))
        else $error("general call enable not written");
    gce_change_a: assert property (
        $changed(general_call_enable) |-> $past(wr_tk, 2))
        else $error("general call enable moved alone");
    irq_rise_a: assert property ($rose(stop_irq[0]) |->
        $past(stop_cond[0], 2) || $past(wr_tk, 3))
        else $error("stop interrupt without cause");
    irq_fall_a: assert property ($fell(stop_irq[0]) |->
        $past(rd_tk, 2) || $past(wr_tk, 3) || $past(gc_reset_cmd[0], 2))
        else $error("stop interrupt dropped without cause");
endmodule // status_checker
bind i2c_slave_status_flags status_checker chk_i (.clock, .rst_n, .hsel,
    .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .stop_cond, .gc_reset_cmd, .general_call_enable, .stop_irq);
`default_nettype wire

/* File: verification/i2c_event_source.sv */
// Stand-in for the I2C master side: one-cycle bus event pulses
`timescale 1ns/100ps
`default_nettype none
module i2c_event_source (
    input wire logic clock,
    output logic [1:0] addr_match,
    output logic [1:0] addr_index0,
    output logic [1:0] addr_index1,
    output logic [1:0] start_byte,
    output logic [1:0] gc_addr,
    output logic [1:0] rep_start,
    output logic [1:0] stop_cond,
    output logic [1:0] gc_reset_cmd,
    output logic [1:0] gc_prog_cmd,
    output logic [1:0] gc_alt_match
);
    logic [1:0] ev [8];
    logic [1:0] idx_ff;
    initial begin
        for (int k = 0; k < 8; k++) ev[k] = 2'b00;
        idx_ff = 2'b00;
    end
    assign addr_match = ev[0];
    assign start_byte = ev[1];
    assign gc_addr = ev[2];
    assign rep_start = ev[3];
    assign stop_cond = ev[4];
    assign gc_reset_cmd = ev[5];
    assign gc_prog_cmd = ev[6];
    assign gc_alt_match = ev[7];
    assign addr_index0 = idx_ff;
    assign addr_index1 = idx_ff;
    // ============================================================
    // Kinds: match, start byte, general call, repeat, stop, reset,
    // program, alternative
    task pulse(input int kind, input int ch, input logic [1:0] idx);
        @(posedge clock);
        ev[kind][ch] <= 1'b1;
        idx_ff <= idx;
        @(posedge clock);
        ev[kind][ch] <= 1'b0;
        idx_ff <= ~idx;
    endtask
endmodule // i2c_event_source
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench of the two-channel status flags block
`timescale 1ns/100ps
`default_nettype none
`include "i2c_status_map.vh"
module testbench;
    logic clock = 1'b0;
    logic rst_n, hsel, hwrite;
    logic [31:0] haddr, hwdata, d;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hready, hreadyout, hresp;
    wire logic [31:0] hrdata;
    wire logic [1:0] addr_match, addr_index0, addr_index1, start_byte;
    wire logic [1:0] gc_addr, rep_start, stop_cond, gc_reset_cmd;
    wire logic [1:0] gc_prog_cmd, gc_alt_match, general_call_enable;
    wire logic [1:0] stop_irq;
    int n_mismatch = 0;
    int num_checks = 0;
    localparam logic [31:0] st0 = `ADDR_STATUS0;
    localparam logic [31:0] st1 = `ADDR_STATUS1;
    localparam logic [31:0] ctl0 = `ADDR_CONTROL0;
    localparam logic [31:0] ctl1 = `ADDR_CONTROL1;
    localparam logic [31:0] all = 32'hffff_ffff;
    assign hready = hreadyout;
    always #12.5 clock = ~clock;
    i2c_slave_status_flags dut (.clock, .rst_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
        .addr_match, .addr_index0, .addr_index1, .start_byte, .gc_addr,
        .rep_start, .stop_cond, .gc_reset_cmd, .gc_prog_cmd,
        .gc_alt_match, .general_call_enable, .stop_irq);
    i2c_event_source ev (.clock, .addr_match, .addr_index0, .addr_index1,
        .start_byte, .gc_addr, .rep_start, .stop_cond, .gc_reset_cmd,
        .gc_prog_cmd, .gc_alt_match);
    // ============================================================
    // Tasks
    task complete_run;
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= `HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        d = hrdata;
    endtask
    task rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        chk(d & m, e);
    endtask
    task irq_chk(input logic [31:0] e);
        #1;
        chk({30'h0, stop_irq}, e);
        @(posedge clock);
    endtask
    initial begin
        repeat (4000) @(posedge clock);
        n_mismatch++;
        complete_run();
    end
    // ============================================================
    // Tests
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        hsize = 3'h2;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(st0, all, 32'h0000_0000);
        rd(st1, all, 32'h0000_0000);
        rd(ctl0, all, 32'h0000_0000);
        rd(32'h0000_0040, all, 32'h0000_0000);
        ev.pulse(0, 0, 2'h2);
        rd(st0, all, 32'h0000_5000);
        ev.pulse(3, 0, 2'h0);
        rd(st0, all, 32'h0000_7000);
        rd(st0, all, 32'h0000_5000);
        ahb(1'b1, ctl0, 32'h0000_0100);
        ev.pulse(3, 0, 2'h0);
        ev.pulse(4, 0, 2'h0);
        @(posedge clock);
        irq_chk(32'h0000_0001);
        rd(st0, 32'hffff_e7ff, 32'h0000_0400);
        irq_chk(32'h0000_0000);
        rd(st0, all, 32'h0000_1000);
        for (int i = 0; i < 4; i++) begin
            ev.pulse(0, 1, i[1:0]);
            rd(st1, 32'h0000_1800, i << 11);
            ev.pulse(4, 1, 2'h0);
            rd(st1, 32'h0000_6400, 32'h0000_0400);
        end
        ahb(1'b1, ctl1, 32'h0000_0100);
        rd(ctl1, all, 32'h0000_0100);
        ev.pulse(0, 1, 2'h1);
        ev.pulse(4, 1, 2'h0);
        @(posedge clock);
        irq_chk(32'h0000_0002);
        rd(st1, 32'h0000_0400, 32'h0000_0400);
        irq_chk(32'h0000_0000);
        ev.pulse(1, 0, 2'h0);
        rd(st0, 32'h0000_4000, 32'h0000_4000);
        ev.pulse(4, 0, 2'h0);
        ev.pulse(2, 0, 2'h0);
        rd(st0, 32'h0000_4000, 32'h0000_0000);
        ahb(1'b1, ctl0, 32'h0000_0004);
        #1;
        chk({30'h0, general_call_enable}, 32'h0000_0001);
        @(posedge clock);
        ev.pulse(2, 0, 2'h0);
        rd(st0, 32'h0000_4000, 32'h0000_4000);
        for (int k = 0; k < 3; k++) begin
            ev.pulse(5 + k, 0, 2'h0);
            rd(st0, 32'h0000_4300, (k + 1) << 8);
            ahb(1'b1, ctl0, 32'h0000_0204);
            rd(st0, 32'h0000_0300, 32'h0000_0000);
        end
        ahb(1'b1, st0, all);
        rd(st0, all, 32'h0000_0000);
        complete_run();
    end
endmodule // testbench
`default_nettype wire
